// ===== design/rfcmc_pkg.sv
package rfcmc_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] RFCMC_CTL_OFS = 8'h00;
    localparam logic [7:0] RFCMC_TRG_OFS = 8'h04;
    localparam logic [7:0] RFCMC_MEAS_OFS = 8'h08;
    localparam logic [7:0] RFCMC_TBASE_OFS = 8'h0C;
    localparam logic [7:0] RFCMC_FLG_OFS = 8'h10;

    // ------------------------------------------------------------
    // control register field positions
    // ------------------------------------------------------------
    localparam int RFCMC_CTL_MODE0_LSB = 0;
    localparam int RFCMC_CTL_MODE1_LSB = 2;
    localparam int RFCMC_CTL_EXT_BIT = 4;
    localparam int RFCMC_CTL_CONT_BIT = 5;
    localparam int RFCMC_CTL_CHAN_BIT = 6;
    localparam int RFCMC_CTL_EN_BIT = 7;

    // trigger register bits
    localparam int RFCMC_TRG_REF_BIT = 0;
    localparam int RFCMC_TRG_SENA_BIT = 1;
    localparam int RFCMC_TRG_SENB_BIT = 2;

    // flag register bits
    localparam int RFCMC_FLG_REF_DONE = 0;
    localparam int RFCMC_FLG_SENA_DONE = 1;
    localparam int RFCMC_FLG_SENB_DONE = 2;
    localparam int RFCMC_FLG_MEAS_OVF = 3;
    localparam int RFCMC_FLG_TBASE_OVF = 4;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int RFCMC_CNT_W = 24;
    localparam logic [23:0] RFCMC_CNT_RST = 24'h000000;
    localparam logic [23:0] RFCMC_CNT_MAX = 24'hFFFFFF;
    localparam logic [1:0] RFCMC_MODE_RST = 2'h0;

    typedef enum logic [1:0] {
        RFCMC_MODE_DC_RES = 2'b00,
        RFCMC_MODE_AC_RES = 2'b01,
        RFCMC_MODE_DC_CAP = 2'b10,
        RFCMC_MODE_RSVD = 2'b11
    } rfcmc_mode_t;

    typedef enum logic [1:0] {
        RFCMC_ST_IDLE = 2'b00,
        RFCMC_ST_REF = 2'b01,
        RFCMC_ST_SENA = 2'b10,
        RFCMC_ST_SENB = 2'b11
    } rfcmc_state_t;

endpackage

// ===== design/rfcmc_core.sv
`timescale 1ns/1ps
// What this block does
// R1 - mode field: DC res, AC res, DC cap
// R2 - each channel keeps its own mode
// R3 - sensor B only in DC resistive mode
// R4 - external enable counts pin pulses instead
// R5 - external mode uses identical start/stop sequence
// R6 - active oscillation clock drives monitor pin
// R7 - continuous bit ignores automatic stop conditions
// R8 - 24-bit presettable measurement up counter
// R9 - 24-bit presettable time base up/down counter
// R10 - time base counts up during reference
// R11 - time base counts down, stops at zero
// R12 - software clears time base before reference
// R13 - software presets measurement counter first
// R14 - measurement overflow in sensor phase is error
// R15 - software saves reference time base count
// R16 - any overflow ends reference, clears start
// R17 - zero or overflow ends sensor, clears start
// R18 - measurement overflow marks reference complete
// R19 - only selected channel oscillates
// R20 - counters writable when idle, kept after stop
// R21 - one count per oscillation period, synchronised
module rfcmc_core
    import rfcmc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cr_osc_clk,
    output logic osc_monitor_out,
    output logic [1:0] ref_drive,
    output logic [1:0] sensor_a_drive,
    output logic [1:0] sensor_b_drive,
    output logic [1:0] ac_bias_en,
    output logic [1:0] cap_mode_en
);

    // ------------------------------------------------------------
    // reset release and oscillation clock synchroniser
    // ------------------------------------------------------------
    logic rst_s1;
    logic rst_s2;
    logic osc_s1;
    logic osc_s2;
    logic osc_s3;
    logic osc_lvl;

    // reset released through two flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    // three flops, level changes once stages two and three agree
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_s3 <= 1'b0;
            osc_lvl <= 1'b0;
        end else begin
            osc_s1 <= cr_osc_clk;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
            if (osc_s2 == osc_s3) begin
                osc_lvl <= osc_s3;
            end
        end
    end

    // ------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------
    logic [1:0] osc_mode_sel [2];
    logic ext_count_en;
    logic continuous_osc_en;
    logic channel_sel;
    logic conv_en;
    logic ref_osc_start;
    logic sensor_a_start;
    logic sensor_b_start;
    logic [23:0] meas_counter;
    logic [23:0] timebase_counter;
    logic ref_done_flag;
    logic sensor_a_done_flag;
    logic sensor_b_done_flag;
    logic meas_ovf_flag;
    logic timebase_ovf_flag;
    rfcmc_state_t state;
    logic osc_prev;

    logic wr;
    logic running;
    logic osc_rise;
    logic meas_wrap;
    logic tbase_wrap;
    logic tbase_zero;
    logic auto_stop;
    logic [1:0] cur_mode;

    assign wr = psel && penable && pwrite;
    assign running = (state != RFCMC_ST_IDLE);
    assign cur_mode = osc_mode_sel[channel_sel];
    // one rising edge per period of the counted clock
    assign osc_rise = osc_lvl && !osc_prev; // R21 R4 R5
    assign meas_wrap = osc_rise && (meas_counter == RFCMC_CNT_MAX);
    assign tbase_wrap = (state == RFCMC_ST_REF)
                        && (timebase_counter == RFCMC_CNT_MAX);
    assign tbase_zero = (state == RFCMC_ST_SENA || state == RFCMC_ST_SENB)
                        && (timebase_counter == 24'h000001);
    assign auto_stop = !continuous_osc_en
                       && (meas_wrap || tbase_wrap || tbase_zero); // R7

    // true when a bus write sets bit b of the register at ofs
    function automatic logic wr_bit(input logic [7:0] ofs, input int b);
        wr_bit = wr && (paddr == ofs) && pwdata[b];
    endfunction

    // ------------------------------------------------------------
    // control register, per channel modes
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            osc_mode_sel[0] <= RFCMC_MODE_RST;
            osc_mode_sel[1] <= RFCMC_MODE_RST;
            ext_count_en <= 1'b0;
            continuous_osc_en <= 1'b0;
            channel_sel <= 1'b0;
            conv_en <= 1'b0;
        end else if (wr && paddr == RFCMC_CTL_OFS && !running) begin
            osc_mode_sel[0] <= pwdata[RFCMC_CTL_MODE0_LSB +: 2]; // R2 R1
            osc_mode_sel[1] <= pwdata[RFCMC_CTL_MODE1_LSB +: 2]; // R2
            ext_count_en <= pwdata[RFCMC_CTL_EXT_BIT]; // R4
            continuous_osc_en <= pwdata[RFCMC_CTL_CONT_BIT]; // R7
            channel_sel <= pwdata[RFCMC_CTL_CHAN_BIT]; // R19
            conv_en <= pwdata[RFCMC_CTL_EN_BIT];
        end
    end

    // ------------------------------------------------------------
    // sequencer: one phase at a time on the selected channel
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            state <= RFCMC_ST_IDLE;
        end else begin
            case (state)
                RFCMC_ST_IDLE: begin
                    if (wr && paddr == RFCMC_TRG_OFS && conv_en) begin
                        if (pwdata[RFCMC_TRG_REF_BIT]) begin
                            state <= RFCMC_ST_REF;
                        end else if (pwdata[RFCMC_TRG_SENA_BIT]) begin
                            state <= RFCMC_ST_SENA;
                        end else if (pwdata[RFCMC_TRG_SENB_BIT]
                                     && cur_mode == RFCMC_MODE_DC_RES) begin
                            state <= RFCMC_ST_SENB; // R3
                        end
                    end
                end
                default: begin
                    // any software trigger write or automatic stop
                    if ((wr && paddr == RFCMC_TRG_OFS) || auto_stop) begin
                        state <= RFCMC_ST_IDLE; // R16 R17
                    end
                end
            endcase
        end
    end

    // start bits mirror the running phase
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            ref_osc_start <= 1'b0;
            sensor_a_start <= 1'b0;
            sensor_b_start <= 1'b0;
            osc_prev <= 1'b0;
        end else begin
            osc_prev <= osc_lvl;
            ref_osc_start <= 1'b0;
            sensor_a_start <= 1'b0;
            sensor_b_start <= 1'b0;
            case (state)
                // any trigger write stops the phase, as in the sequencer
                RFCMC_ST_REF: ref_osc_start <= !auto_stop
                    && !(wr && paddr == RFCMC_TRG_OFS); // R16
                RFCMC_ST_SENA: sensor_a_start <= !auto_stop
                    && !(wr && paddr == RFCMC_TRG_OFS); // R17
                RFCMC_ST_SENB: sensor_b_start <= !auto_stop
                    && !(wr && paddr == RFCMC_TRG_OFS); // R17
                default: begin
                    if (wr && paddr == RFCMC_TRG_OFS && conv_en) begin
                        ref_osc_start <= pwdata[RFCMC_TRG_REF_BIT];
                        sensor_a_start <= !pwdata[RFCMC_TRG_REF_BIT]
                            && pwdata[RFCMC_TRG_SENA_BIT];
                        sensor_b_start <= !pwdata[RFCMC_TRG_REF_BIT]
                            && !pwdata[RFCMC_TRG_SENA_BIT]
                            && pwdata[RFCMC_TRG_SENB_BIT]
                            && cur_mode == RFCMC_MODE_DC_RES;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // counters
    // ------------------------------------------------------------
    // measurement counter: preset when idle, counts oscillation edges
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            meas_counter <= RFCMC_CNT_RST;
        end else if (!running) begin
            if (wr && paddr == RFCMC_MEAS_OFS) begin
                meas_counter <= pwdata[23:0]; // R20 R8
            end
        end else if (osc_rise) begin
            meas_counter <= meas_counter + 24'h000001; // R8
        end
    end

    // time base counter: up in reference, down in sensor phase
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            timebase_counter <= RFCMC_CNT_RST;
        end else begin
            case (state)
                RFCMC_ST_IDLE: begin
                    if (wr && paddr == RFCMC_TBASE_OFS) begin
                        timebase_counter <= pwdata[23:0]; // R20 R9
                    end
                end
                RFCMC_ST_REF: begin
                    timebase_counter <= timebase_counter + 24'h000001; // R10
                end
                default: begin
                    if (timebase_counter != RFCMC_CNT_RST) begin
                        timebase_counter <= timebase_counter - 24'h000001; // R11
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // completion and error flags, write one to clear, set wins
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            ref_done_flag <= 1'b0;
            sensor_a_done_flag <= 1'b0;
            sensor_b_done_flag <= 1'b0;
            meas_ovf_flag <= 1'b0;
            timebase_ovf_flag <= 1'b0;
        end else begin
            if (wr_bit(RFCMC_FLG_OFS, RFCMC_FLG_REF_DONE))
                ref_done_flag <= 1'b0;
            if (wr_bit(RFCMC_FLG_OFS, RFCMC_FLG_SENA_DONE))
                sensor_a_done_flag <= 1'b0;
            if (wr_bit(RFCMC_FLG_OFS, RFCMC_FLG_SENB_DONE))
                sensor_b_done_flag <= 1'b0;
            if (wr_bit(RFCMC_FLG_OFS, RFCMC_FLG_MEAS_OVF))
                meas_ovf_flag <= 1'b0;
            if (wr_bit(RFCMC_FLG_OFS, RFCMC_FLG_TBASE_OVF))
                timebase_ovf_flag <= 1'b0;
            if (state == RFCMC_ST_REF && meas_wrap)
                ref_done_flag <= 1'b1; // R18
            if (tbase_wrap)
                timebase_ovf_flag <= 1'b1; // R16
            if (state == RFCMC_ST_SENA && tbase_zero)
                sensor_a_done_flag <= 1'b1; // R17
            if (state == RFCMC_ST_SENB && tbase_zero)
                sensor_b_done_flag <= 1'b1; // R17
            if ((state == RFCMC_ST_SENA || state == RFCMC_ST_SENB)
                && meas_wrap)
                meas_ovf_flag <= 1'b1; // R14
        end
    end

    // ------------------------------------------------------------
    // pin side drive and monitor output
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            osc_monitor_out <= 1'b0;
            ref_drive <= 2'b00;
            sensor_a_drive <= 2'b00;
            sensor_b_drive <= 2'b00;
            ac_bias_en <= 2'b00;
            cap_mode_en <= 2'b00;
        end else begin
            osc_monitor_out <= running && osc_lvl; // R6
            ref_drive <= 2'b00;
            sensor_a_drive <= 2'b00;
            sensor_b_drive <= 2'b00;
            if (!ext_count_en) begin
                ref_drive[channel_sel] <= (state == RFCMC_ST_REF); // R19
                sensor_a_drive[channel_sel] <= (state == RFCMC_ST_SENA);
                sensor_b_drive[channel_sel] <= (state == RFCMC_ST_SENB); // R3
            end
            for (int i = 0; i < 2; i++) begin
                ac_bias_en[i] <= (osc_mode_sel[i] == RFCMC_MODE_AC_RES); // R1
                cap_mode_en[i] <= (osc_mode_sel[i] == RFCMC_MODE_DC_CAP); // R1
            end
        end
    end

    // ------------------------------------------------------------
    // APB read side, single cycle answer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (psel && !penable) begin
                case (paddr)
                    RFCMC_CTL_OFS: prdata <= {24'h000000, conv_en,
                        channel_sel, continuous_osc_en, ext_count_en,
                        osc_mode_sel[1], osc_mode_sel[0]};
                    RFCMC_TRG_OFS: prdata <= {29'h00000000,
                        sensor_b_start, sensor_a_start, ref_osc_start};
                    RFCMC_MEAS_OFS: prdata <= {8'h00, meas_counter};
                    RFCMC_TBASE_OFS: prdata <= {8'h00, timebase_counter};
                    RFCMC_FLG_OFS: prdata <= {27'h0000000,
                        timebase_ovf_flag, meas_ovf_flag,
                        sensor_b_done_flag, sensor_a_done_flag,
                        ref_done_flag};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_ref_stop;
        @(posedge clk) disable iff (!rst_s2)
        (state == RFCMC_ST_REF && tbase_wrap && !continuous_osc_en)
            |=> (state == RFCMC_ST_IDLE && timebase_ovf_flag);
    endproperty
    a_ref_stop: assert property (p_ref_stop) // R16
        else $error("reference did not stop on time base overflow");

    property p_ref_done;
        @(posedge clk) disable iff (!rst_s2)
        (state == RFCMC_ST_REF && meas_wrap) |=> ref_done_flag;
    endproperty
    a_ref_done: assert property (p_ref_done) // R18
        else $error("reference done flag missing");

    property p_sens_zero;
        @(posedge clk) disable iff (!rst_s2)
        (tbase_zero && !continuous_osc_en)
            |=> (timebase_counter == RFCMC_CNT_RST && !running);
    endproperty
    a_sens_zero: assert property (p_sens_zero) // R11
        else $error("sensor phase did not end at zero");

    property p_meas_ovf;
        @(posedge clk) disable iff (!rst_s2)
        ((state == RFCMC_ST_SENA || state == RFCMC_ST_SENB) && meas_wrap)
            |=> meas_ovf_flag;
    endproperty
    a_meas_ovf: assert property (p_meas_ovf) // R14
        else $error("measurement overflow not flagged");

    property p_cont;
        @(posedge clk) disable iff (!rst_s2)
        (running && continuous_osc_en && !wr) |=> running;
    endproperty
    a_cont: assert property (p_cont) // R7
        else $error("continuous oscillation stopped by itself");

    sequence s_ref_run;
        state == RFCMC_ST_REF && !auto_stop && !wr;
    endsequence
    property p_tbase_up;
        @(posedge clk) disable iff (!rst_s2)
        s_ref_run |=> timebase_counter == $past(timebase_counter) + 24'h1;
    endproperty
    a_tbase_up: assert property (p_tbase_up) // R10
        else $error("time base did not count up");

    property p_meas_step;
        @(posedge clk) disable iff (!rst_s2)
        (running && !osc_rise) |=> meas_counter == $past(meas_counter);
    endproperty
    a_meas_step: assert property (p_meas_step) // R21
        else $error("measurement counter moved without an edge");

    // start bits always name the phase that is running
    property p_start_bits;
        @(posedge clk) disable iff (!rst_s2)
        {sensor_b_start, sensor_a_start, ref_osc_start}
            == {state == RFCMC_ST_SENB, state == RFCMC_ST_SENA,
                state == RFCMC_ST_REF};
    endproperty
    a_start_bits: assert property (p_start_bits) // R17
        else $error("start bits disagree with the running phase");

    property p_mon;
        @(posedge clk) disable iff (!rst_s2)
        !running |=> !osc_monitor_out;
    endproperty
    a_mon: assert property (p_mon) // R6
        else $error("monitor output active while idle");

    property p_senb;
        @(posedge clk) disable iff (!rst_s2)
        (state == RFCMC_ST_SENB) |-> (cur_mode == RFCMC_MODE_DC_RES);
    endproperty
    a_senb: assert property (p_senb) // R3
        else $error("sensor B running outside DC resistive mode");

endmodule

// ===== test/rfcmc_osc_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// cr oscillator and external pulse source
// ------------------------------------------------------------
module rfcmc_osc_model #(
    parameter int HALF_NS = 203,
    parameter int EXT_HALF_NS = 131
) (
    input wire logic [1:0] ref_drive,
    input wire logic [1:0] sensor_a_drive,
    input wire logic [1:0] sensor_b_drive,
    input wire logic ext_run,
    output logic cr_osc_clk
);
    logic osc_on;

    // the rc node swings only while some element is driven
    assign osc_on = |{ref_drive, sensor_a_drive, sensor_b_drive};

    // free of the bus clock; rests low between conversions
    always begin
        if (osc_on || ext_run) begin
            #(ext_run ? EXT_HALF_NS : HALF_NS);
            cr_osc_clk = (osc_on || ext_run) ? ~cr_osc_clk : 1'b0;
        end else begin
            cr_osc_clk = 1'b0;
            @(osc_on or ext_run);
        end
    end
endmodule

// ===== test/rfcmc_core_tb_top.sv
`timescale 1ns/1ps
module rfcmc_core_tb_top
    import rfcmc_pkg::*;
;
    typedef struct {
        logic [31:0] ctl;
        logic [1:0] ac;
        logic [1:0] cap;
    } rfcmc_row_t;

    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, cr_osc_clk, osc_monitor_out;
    logic [1:0] ref_drive, sensor_a_drive, sensor_b_drive;
    logic [1:0] ac_bias_en, cap_mode_en;
    logic ext_run = 1'b0;
    int err_count = 0;
    int samples_checked = 0;
    logic [31:0] rd;
    logic rerr;
    logic [5:0] drv_seen;
    logic mon_seen;
    rfcmc_row_t rows [5] = '{'{32'h00000080, 2'h0, 2'h0},
        '{32'h00000084, 2'h2, 2'h0}, '{32'h00000089, 2'h1, 2'h2},
        '{32'h00000086, 2'h2, 2'h1}, '{32'h0000008F, 2'h0, 2'h0}};

    // ------------------------------------------------------------
    // clock, design and far side
    // ------------------------------------------------------------
    always #20 clk = ~clk;

    rfcmc_core dut (.clk(clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cr_osc_clk(cr_osc_clk),
        .osc_monitor_out(osc_monitor_out), .ref_drive(ref_drive),
        .sensor_a_drive(sensor_a_drive),
        .sensor_b_drive(sensor_b_drive), .ac_bias_en(ac_bias_en),
        .cap_mode_en(cap_mode_en));

    rfcmc_osc_model osc (.ref_drive(ref_drive),
        .sensor_a_drive(sensor_a_drive),
        .sensor_b_drive(sensor_b_drive), .ext_run(ext_run),
        .cr_osc_clk(cr_osc_clk));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic in_range(input logic [31:0] v, input logic [31:0] lo,
                            input logic [31:0] hi);
        check({31'h0, (v >= lo) && (v <= hi)}, 32'h00000001);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked,
                 err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            err_count++;
            complete_run();
        end
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // preset counters, clear flags, fire the trigger
    task automatic start(input logic [31:0] ctl, input logic [31:0] mc,
                         input logic [31:0] tc, input logic [31:0] trg);
        apb(1'b1, RFCMC_CTL_OFS, ctl);
        apb(1'b1, RFCMC_MEAS_OFS, mc);
        apb(1'b1, RFCMC_TBASE_OFS, tc);
        apb(1'b1, RFCMC_FLG_OFS, 32'h0000001F);
        apb(1'b1, RFCMC_TRG_OFS, trg);
    endtask

    // run one conversion to its automatic stop and check its outcome
    task automatic conv(input logic [31:0] ctl, input logic [31:0] mc,
                        input logic [31:0] tc, input logic [31:0] trg,
                        input logic [5:0] drv, input logic [31:0] flg);
        int n;
        start(ctl, mc, tc, trg);
        drv_seen = 6'h00;
        mon_seen = 1'b0;
        for (n = 0; n < 200; n++) begin
            apb(1'b0, RFCMC_TRG_OFS, 32'h00000000);
            drv_seen = drv_seen | {ref_drive, sensor_a_drive, sensor_b_drive};
            mon_seen = mon_seen | osc_monitor_out;
            if (rd[2:0] === 3'h0) break;
        end
        if (n == 200) begin
            err_count++;
            complete_run();
        end
        check({26'h0, drv_seen}, {26'h0, drv});
        check({31'h0, mon_seen}, 32'h00000001);
        check({31'h0, osc_monitor_out}, 32'h00000000);
        apb(1'b0, RFCMC_FLG_OFS, 32'h00000000);
        check(rd, flg);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        // every register reads zero after reset, mode field dc resistive
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(i * 4), 32'h00000000);
            check(rd, 32'h00000000);
        end
        apb(1'b0, 8'h14, 32'h00000000);
        check({31'h0, rerr}, 32'h00000001);
        // mode decode per channel
        foreach (rows[i]) begin
            apb(1'b1, RFCMC_CTL_OFS, rows[i].ctl);
            apb(1'b0, RFCMC_CTL_OFS, 32'h00000000);
            check(rd, rows[i].ctl);
            check({30'h0, ac_bias_en}, {30'h0, rows[i].ac});
            check({30'h0, cap_mode_en}, {30'h0, rows[i].cap});
        end
        // reference ends on measurement wrap after 16 periods
        conv(32'h80, 32'hFFFFF0, 32'h0, 32'h1, 6'h10, 32'h1);
        apb(1'b0, RFCMC_MEAS_OFS, 32'h00000000);
        check(rd, 32'h00000000);
        apb(1'b0, RFCMC_TBASE_OFS, 32'h00000000);
        in_range(rd, 32'd150, 32'd172);
        // time base wrap ends the reference as an error
        conv(32'h80, 32'h0, 32'hFFFFF0, 32'h1, 6'h10, 32'h10);
        // sensor a from a saved time base value
        conv(32'h80, 32'h0, 32'd100, 32'h2, 6'h04, 32'h2);
        apb(1'b0, RFCMC_TBASE_OFS, 32'h00000000);
        check(rd, 32'h00000000);
        apb(1'b0, RFCMC_MEAS_OFS, 32'h00000000);
        in_range(rd, 32'd8, 32'd11);
        // measurement overflow cancels the sensor phase
        conv(32'h80, 32'hFFFFFE, 32'd1000, 32'h2, 6'h04, 32'h8);
        apb(1'b0, RFCMC_TBASE_OFS, 32'h00000000);
        in_range(rd, 32'd900, 32'd999);
        // sensor b on channel 1
        conv(32'hC0, 32'h0, 32'd30, 32'h4, 6'h02, 32'h4);
        // external pulses drive the same reference sequence
        ext_run <= 1'b1;
        conv(32'h90, 32'hFFFFF8, 32'h0, 32'h1, 6'h00, 32'h1);
        ext_run <= 1'b0;
        apb(1'b0, RFCMC_MEAS_OFS, 32'h00000000);
        check(rd, 32'h00000000);
        // sensor b refused outside dc resistive mode, start needs enable
        start(32'h81, 32'h0, 32'd30, 32'h4);
        apb(1'b0, RFCMC_TRG_OFS, 32'h00000000);
        check(rd, 32'h00000000);
        start(32'h00, 32'h0, 32'h0, 32'h1);
        apb(1'b0, RFCMC_TRG_OFS, 32'h00000000);
        check(rd, 32'h00000000);
        // continuous oscillation runs past a zero time base
        start(32'hA0, 32'h0, 32'd20, 32'h2);
        repeat (60) @(posedge clk);
        apb(1'b0, RFCMC_TRG_OFS, 32'h00000000);
        check({29'h0, rd[2:0]}, 32'h00000002);
        apb(1'b1, RFCMC_MEAS_OFS, 32'h00000123);
        apb(1'b1, RFCMC_TRG_OFS, 32'h00000000);
        apb(1'b0, RFCMC_TRG_OFS, 32'h00000000);
        check(rd, 32'h00000000);
        apb(1'b0, RFCMC_MEAS_OFS, 32'h00000000);
        in_range(rd, 32'h1, 32'h122);
        complete_run();
    end

    // hang guard
    initial begin
        #3000000;
        err_count++;
        complete_run();
    end
endmodule
